// [rtl/lbh_pkg.sv]
package lbh_pkg;

    // Image numbers steered by the image-select pin
    localparam logic LBH_IMAGE0 = 1'h0;
    localparam logic LBH_IMAGE1 = 1'h1;

    // Values after reset
    localparam logic LBH_SWRST_RST = 1'h0;
    localparam logic LBH_PCIDIS_RST = 1'h0;
    localparam logic [1:0] LBH_SYNC_RST = 2'h3;
    // Idle levels of the synchronised pins; selects, resets, INT# high
    localparam logic [6:0] LBH_PIN_RST = 7'h67;

    // Clock-stability guard: cycles the clock-good level must hold
    localparam int LBH_CLK_HZ = 10000000;
    localparam int LBH_STABLE_US = 4;
    localparam int LBH_STABLE_CYC = (LBH_STABLE_US * (LBH_CLK_HZ / 1000000));
    localparam logic [7:0] LBH_STABLE_CNT = 8'(LBH_STABLE_CYC);

    // Access decoder states
    typedef enum logic [2:0] {
        LBH_ST_IDLE = 3'b001,
        LBH_ST_REG = 3'b010,
        LBH_ST_PCI = 3'b100
    } lbh_state_t;

endpackage

// [rtl/lbh_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for a level arriving from a pin
module lbh_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Level in and out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_r; // First stage, read only by the second

    // Both stages preload the idle level so no false edge follows reset
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= RST;
            q_o <= RST;
        end else if (ce_i) begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule

// [rtl/lbh_top.sv]
`timescale 1ns/1ps
module lbh_top (
    // Clock, PCI reset (global), clock enable
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Local bus selects and image select
    input wire logic register_space_select_n_i,
    input wire logic pci_window_select_n_i,
    input wire logic transfer_start_n_i,
    input wire logic slave_image_select_i,
    input wire logic clock_stable_i,
    // Software reset bit control (from register logic)
    input wire logic software_reset_bit_set_i,
    input wire logic software_reset_bit_clr_i,
    // Reset options and reset pins
    input wire logic local_reset_in_n_i,
    input wire logic hot_swap_good_n_i,
    input wire logic pci_disable_option_i,
    input wire logic pci_disable_clr_i,
    // Interrupt mode: 1 = host bridging, 0 = adapter card
    input wire logic host_mode_i,
    input wire logic pci_int_n_i,
    input wire logic local_interrupt_n_i,
    // Access decode outputs
    output logic reg_access_o,
    output logic pci_access_o,
    output logic image_o,
    output logic access_dropped_o,
    // PCI target retry and status
    output logic pci_target_retry_o,
    output logic pci_disable_status_o,
    output logic software_reset_bit_o,
    // Reset and interrupt outputs
    output logic reset_out_n_o,
    output logic local_interrupt_n_o,
    output logic local_interrupt_oe_o,
    output logic pci_int_n_o,
    output logic pci_int_oe_o
);

    // Synchronised pin levels
    logic [6:0] pin_raw;
    logic [6:0] pin_s;
    logic reg_sel_s;
    logic pci_sel_s;
    logic img_s;
    logic clk_ok_s;
    logic lrst_n_s;
    logic hs_n_s;
    logic pint_n_s;
    logic lint_n_s;

    assign pin_raw = {register_space_select_n_i, pci_window_select_n_i,
                      slave_image_select_i, clock_stable_i,
                      local_reset_in_n_i, hot_swap_good_n_i,
                      pci_int_n_i};

    lbh_sync #(.W(7), .RST(lbh_pkg::LBH_PIN_RST)) u_sync (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    assign reg_sel_s = ~pin_s[6];
    assign pci_sel_s = ~pin_s[5];
    assign img_s = pin_s[4];
    assign clk_ok_s = pin_s[3];
    assign lrst_n_s = pin_s[2];
    assign hs_n_s = pin_s[1];
    assign pint_n_s = pin_s[0];

    // Local interrupt pin sampled through its own pair of flops
    logic [1:0] lint_sync_r;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            lint_sync_r <= lbh_pkg::LBH_SYNC_RST;
        end else if (ce_i) begin
            lint_sync_r <= {lint_sync_r[0], local_interrupt_n_i};
        end
    end
    assign lint_n_s = lint_sync_r[1];

    // Clock stability counter: bus is trusted only after a quiet spell
    logic [7:0] stable_cnt_r;
    logic clk_good;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            stable_cnt_r <= 8'h00;
        end else if (ce_i) begin
            if (!clk_ok_s) begin
                stable_cnt_r <= 8'h00;
            end else if (stable_cnt_r != lbh_pkg::LBH_STABLE_CNT) begin
                stable_cnt_r <= stable_cnt_r + 8'h01;
            end
        end
    end
    assign clk_good = (stable_cnt_r == lbh_pkg::LBH_STABLE_CNT);

    // Access decoder; one access per select assertion
    lbh_pkg::lbh_state_t state_r;
    lbh_pkg::lbh_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            lbh_pkg::LBH_ST_IDLE: begin
                if (reg_sel_s && clk_good) begin
                    state_nxt = lbh_pkg::LBH_ST_REG;
                end else if (pci_sel_s && clk_good) begin
                    state_nxt = lbh_pkg::LBH_ST_PCI;
                end
            end
            lbh_pkg::LBH_ST_REG: begin
                if (!reg_sel_s) begin
                    state_nxt = lbh_pkg::LBH_ST_IDLE;
                end
            end
            lbh_pkg::LBH_ST_PCI: begin
                if (!pci_sel_s) begin
                    state_nxt = lbh_pkg::LBH_ST_IDLE;
                end
            end
            default: state_nxt = lbh_pkg::LBH_ST_IDLE;
        endcase
    end

    // State register; PCI reset clears it like all other state
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= lbh_pkg::LBH_ST_IDLE;
        end else if (ce_i) begin
            state_r <= state_nxt;
        end
    end

    // Access pulses and the image latched at window access start
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_access_o <= 1'h0;
            pci_access_o <= 1'h0;
            image_o <= lbh_pkg::LBH_IMAGE0;
            access_dropped_o <= 1'h0;
        end else if (ce_i) begin
            reg_access_o <= (state_r == lbh_pkg::LBH_ST_IDLE) &&
                            (state_nxt == lbh_pkg::LBH_ST_REG);
            pci_access_o <= (state_r == lbh_pkg::LBH_ST_IDLE) &&
                            (state_nxt == lbh_pkg::LBH_ST_PCI);
            // Selects seen before the clock settles are flagged as dropped; one still held once it is good is served
            access_dropped_o <= (state_r == lbh_pkg::LBH_ST_IDLE) &&
                                (reg_sel_s || pci_sel_s) &&
                                !clk_good;
            if ((state_r == lbh_pkg::LBH_ST_IDLE) &&
                (state_nxt == lbh_pkg::LBH_ST_PCI)) begin
                image_o <= img_s ? lbh_pkg::LBH_IMAGE1
                                 : lbh_pkg::LBH_IMAGE0;
            end
        end
    end

    // Reset-option capture at local reset release or hot-swap good assertion
    logic lrst_n_d_r;
    logic hs_n_d_r;
    logic opt_first_r;
    logic opt_edge;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            lrst_n_d_r <= 1'h1;
            hs_n_d_r <= 1'h1;
            opt_first_r <= 1'h1;
        end else if (ce_i) begin
            lrst_n_d_r <= lrst_n_s;
            hs_n_d_r <= hs_n_s;
            opt_first_r <= 1'h0;
        end
    end
    // First enabled cycle after PCI reset release counts as its edge
    assign opt_edge = opt_first_r || (lrst_n_s && !lrst_n_d_r) ||
                      (!hs_n_s && hs_n_d_r);

    // Disable status: set by the strap, cleared by software; set wins
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            pci_disable_status_o <= lbh_pkg::LBH_PCIDIS_RST;
        end else if (ce_i) begin
            if (opt_edge && pci_disable_option_i) begin
                pci_disable_status_o <= 1'h1;
            end else if (pci_disable_clr_i) begin
                pci_disable_status_o <= 1'h0;
            end
        end
    end
    assign pci_target_retry_o = pci_disable_status_o;

    // Software reset bit; software sets and clears it
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            software_reset_bit_o <= lbh_pkg::LBH_SWRST_RST;
        end else if (ce_i) begin
            if (software_reset_bit_set_i) begin
                software_reset_bit_o <= 1'h1;
            end else if (software_reset_bit_clr_i) begin
                software_reset_bit_o <= 1'h0;
            end
        end
    end

    // Reset output: low while PCI reset or the software bit holds
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            reset_out_n_o <= 1'h0;
        end else if (ce_i) begin
            reset_out_n_o <= !software_reset_bit_o;
        end
    end

    // Interrupt forwarding, direction set by the application mode
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            local_interrupt_n_o <= 1'h1;
            pci_int_n_o <= 1'h1;
        end else if (ce_i) begin
            local_interrupt_n_o <= pint_n_s;
            pci_int_n_o <= lint_n_s;
        end
    end
    // Open-drain style: drive only when asserting low
    assign local_interrupt_oe_o = host_mode_i && !local_interrupt_n_o;
    assign pci_int_oe_o = !host_mode_i && !pci_int_n_o;

    // Checks
    a_image_one_sel: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && state_r == lbh_pkg::LBH_ST_IDLE && clk_good && !reg_sel_s
         && pci_sel_s && img_s) |=> (image_o == 1'h1 && pci_access_o))
        else $error("image one not chosen");
    a_image_zero_sel: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && state_r == lbh_pkg::LBH_ST_IDLE && clk_good && !reg_sel_s
         && pci_sel_s && !img_s) |=> (image_o == 1'h0 && pci_access_o))
        else $error("image zero not chosen");
    a_no_access_unstable: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && !clk_good) |=> (!reg_access_o && !pci_access_o))
        else $error("access served on unstable clock");
    a_swrst_drives_out: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && software_reset_bit_set_i) ##1 ce_i [*2]
        |-> !reset_out_n_o)
        else $error("reset output not asserted by bit");
    a_rstout_release: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && !software_reset_bit_o) |=> reset_out_n_o)
        else $error("reset output stuck");
    a_rstout_hold: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && software_reset_bit_o) |=> !reset_out_n_o)
        else $error("reset output released early");
    a_retry_until_clr: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (pci_disable_status_o && !(ce_i && pci_disable_clr_i))
        |=> pci_target_retry_o)
        else $error("retry dropped before clear");
    a_host_int_fwd: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && !pint_n_s) |=> !local_interrupt_n_o)
        else $error("pci interrupt not forwarded");
    a_card_int_fwd: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && !lint_n_s) |=> !pci_int_n_o)
        else $error("local interrupt not forwarded");
    a_option_capture: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (ce_i && opt_edge && pci_disable_option_i)
        |=> pci_disable_status_o)
        else $error("disable option not captured");

endmodule

// [bench/lbh_cpu_model.sv]
`timescale 1ns/1ps
// Processor side of the local bus, clocked with the bridge
module lbh_cpu_model (
    // Shared bus clock
    input wire logic mclk_i,
    // Selects and transfer start idle high, image pin idles low
    output logic register_space_select_n_o,
    output logic pci_window_select_n_o,
    output logic transfer_start_n_o,
    output logic slave_image_select_o
);
    // Control lines idle inactive; no bus cycle starts while idle
    initial begin
        register_space_select_n_o = 1'h1;
        pci_window_select_n_o = 1'h1;
        transfer_start_n_o = 1'h1;
        slave_image_select_o = 1'h0;
    end
    // Port write that moves the image pin before the access
    task automatic set_image(input logic img);
        @(negedge mclk_i);
        slave_image_select_o = img;
    endtask
    // Hold one of the two selects low, then release both
    task automatic access(input logic win, input int cyc);
        @(negedge mclk_i);
        if (win) begin
            pci_window_select_n_o = 1'h0;
        end else begin
            register_space_select_n_o = 1'h0;
        end
        repeat (cyc) @(negedge mclk_i);
        register_space_select_n_o = 1'h1;
        pci_window_select_n_o = 1'h1;
    endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
// Self-checking bench; inputs move on the falling edge
module testbench;
    logic mclk_i = 1'h0;
    logic reset_i = 1'h1;
    logic stab = 1'h0, sw_set = 1'h0, sw_clr = 1'h0, lrst_n = 1'h1;
    logic hs_n = 1'h1, dis_opt = 1'h1, dis_clr = 1'h0, host = 1'h1;
    logic pint_n = 1'h1, lint_n = 1'h1, ce = 1'h1;
    logic rsel_n, wsel_n, ts_n, img, reg_acc, pci_acc, image, drop;
    logic retry, dis_st, sw_bit, rst_n, lint_o, lint_oe, pint_o, pint_oe;
    int n_fail = 0, n_tests = 0, n_reg = 0, n_pci = 0, n_drop = 0;
    int cyc = 0;

    // 10 MHz clock
    always #50 mclk_i = ~mclk_i;

    lbh_cpu_model i_lbh_cpu_model (.mclk_i(mclk_i),
        .register_space_select_n_o(rsel_n), .pci_window_select_n_o(wsel_n),
        .transfer_start_n_o(ts_n), .slave_image_select_o(img));

    lbh_top i_lbh_top (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce),
        .register_space_select_n_i(rsel_n), .pci_window_select_n_i(wsel_n),
        .transfer_start_n_i(ts_n), .slave_image_select_i(img),
        .clock_stable_i(stab), .software_reset_bit_set_i(sw_set),
        .software_reset_bit_clr_i(sw_clr), .local_reset_in_n_i(lrst_n),
        .hot_swap_good_n_i(hs_n), .pci_disable_option_i(dis_opt),
        .pci_disable_clr_i(dis_clr), .host_mode_i(host),
        .pci_int_n_i(pint_n), .local_interrupt_n_i(lint_n),
        .reg_access_o(reg_acc), .pci_access_o(pci_acc), .image_o(image),
        .access_dropped_o(drop), .pci_target_retry_o(retry),
        .pci_disable_status_o(dis_st), .software_reset_bit_o(sw_bit),
        .reset_out_n_o(rst_n), .local_interrupt_n_o(lint_o),
        .local_interrupt_oe_o(lint_oe), .pci_int_n_o(pint_o),
        .pci_int_oe_o(pint_oe));

    // Pulses counted mid-cycle where settled; also the hang limit
    always @(negedge mclk_i) begin
        n_reg += int'(reg_acc === 1'h1);
        n_pci += int'(pci_acc === 1'h1);
        n_drop += int'(drop === 1'h1);
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_n(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            n_fail++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // One cycle pulse on a bench-driven strobe
    task automatic pulse(ref logic s);
        s = 1'h1;
        ticks(1);
        s = 1'h0;
    endtask

    task automatic t_reset();
        chk("reset_out_n", 1'h0, rst_n);
        chk("image", 1'h0, image);
        chk("local_int_oe", 1'h0, lint_oe);
        reset_i = 1'h0;
        ticks(3);
        chk("reset_out_n", 1'h1, rst_n);
        chk("pci_target_retry", 1'h1, retry);
        dis_opt = 1'h0;
        pulse(dis_clr);
        ticks(1);
        chk("pci_target_retry", 1'h0, retry);
        $display("t_reset done");
    endtask

    task automatic t_access();
        int r0 = n_reg;
        int p0 = n_pci;
        int d0 = n_drop;
        logic exp_img;
        // Select while the clock is not yet good is dropped
        i_lbh_cpu_model.access(1'h0, 6);
        ticks(3);
        chk_n("dropped", 1, int'(n_drop > d0));
        chk_n("reg_access", r0, n_reg);
        stab = 1'h1;
        ticks(46);
        // Held select is served once only
        i_lbh_cpu_model.access(1'h0, 6);
        ticks(3);
        chk_n("reg_access", r0 + 1, n_reg);
        chk_n("pci_access", p0, n_pci);
        // Image 1 first, then back to image 0
        for (int k = 0; k < 2; k++) begin
            i_lbh_cpu_model.set_image(k == 0);
            ticks(3);
            i_lbh_cpu_model.access(1'h1, 6);
            ticks(3);
            exp_img = (k == 0) ? lbh_pkg::LBH_IMAGE1 : lbh_pkg::LBH_IMAGE0;
            chk("image", exp_img, image);
            chk_n("pci_access", p0 + k + 1, n_pci);
        end
        $display("t_access done");
    endtask

    task automatic t_irq();
        pint_n = 1'h0;
        ticks(4);
        chk("local_int_n", 1'h0, lint_o);
        chk("local_int_oe", 1'h1, lint_oe);
        chk("pci_int_oe", 1'h0, pint_oe);
        pint_n = 1'h1;
        host = 1'h0;
        lint_n = 1'h0;
        ticks(4);
        chk("pci_int_n", 1'h0, pint_o);
        chk("pci_int_oe", 1'h1, pint_oe);
        chk("local_int_oe", 1'h0, lint_oe);
        lint_n = 1'h1;
        ticks(4);
        chk("pci_int_oe", 1'h0, pint_oe);
        $display("t_irq done");
    endtask

    task automatic t_option();
        dis_opt = 1'h1;
        lrst_n = 1'h0;
        ticks(4);
        chk("pci_disable_status", 1'h0, dis_st);
        lrst_n = 1'h1;
        ticks(5);
        chk("pci_disable_status", 1'h1, dis_st);
        pulse(dis_clr);
        ticks(1);
        hs_n = 1'h0;
        ticks(5);
        chk("pci_disable_status", 1'h1, dis_st);
        pulse(dis_clr);
        dis_opt = 1'h0;
        ticks(1);
        chk("pci_disable_status", 1'h0, dis_st);
        $display("t_option done");
    endtask

    task automatic t_swreset();
        // Frozen clock enable: a set pulse must not land
        ce = 1'h0;
        pulse(sw_set);
        ticks(1);
        chk("software_reset_bit", 1'h0, sw_bit);
        chk("reset_out_n", 1'h1, rst_n);
        ce = 1'h1;
        pulse(sw_set);
        ticks(1);
        chk("software_reset_bit", 1'h1, sw_bit);
        ticks(5);
        chk("reset_out_n", 1'h0, rst_n);
        pulse(sw_clr);
        chk("reset_out_n", 1'h0, rst_n);
        ticks(2);
        chk("reset_out_n", 1'h1, rst_n);
        // Global reset in mid-run clears the bit
        pulse(sw_set);
        ticks(3);
        reset_i = 1'h1;
        ticks(1);
        chk("software_reset_bit", 1'h0, sw_bit);
        chk("reset_out_n", 1'h0, rst_n);
        reset_i = 1'h0;
        ticks(3);
        chk("reset_out_n", 1'h1, rst_n);
        $display("t_swreset done");
    endtask

    // Main sequence: reset held for 3 cycles
    initial begin
        ticks(3);
        t_reset();
        t_access();
        t_irq();
        t_option();
        t_swreset();
        print_verdict();
    end
endmodule
